// ---- hw/lsr_refresh.sv ----
// Purpose: Device-side refresh, self-refresh and bank masking logic
// Assumes: cmd pins synchronous to sys_clk; pin clock gating not modelled
// Notes:   Refresh engine is a single shared bank-busy tracker
`include "lsr_map.svh"
`default_nettype none
module lsr_refresh
  import lsr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic [9:0] cmd_addr,
  input  wire logic       mrw_valid,
  input  wire logic [7:0] mrw_addr,
  input  wire logic [7:0] mrw_data,
  output logic            self_refresh_q,
  output logic            int_clk_en_q,
  output logic            exit_busy_q,
  output logic [7:0]      bank_refresh_q,
  output logic [7:0]      seg_refresh_q,
  output logic [2:0]      pb_bank_q,
  output logic [7:0]      bank_busy_q
);
  lsr_state_type state_q;
  logic          cke_prev_q;
  logic [7:0]    bank_mask_q;
  logic [7:0]    seg_mask_q;
  logic [15:0]   cnt_q;
  logic [15:0]   sr_timer_q;
  logic [15:0]   rfc_q;
  logic          sr_done_q;
  logic          is_refresh;
  logic          sr_entry;
  logic          ref_ab;
  logic          ref_pb;

  // Command decode on the sampled edge
  assign is_refresh = !cs_n && !cmd_addr[0] && !cmd_addr[1] && cmd_addr[2];
  assign sr_entry   = is_refresh && !cke && cke_prev_q;
  assign ref_ab     = is_refresh && cke && cmd_addr[3] &&
                      (state_q == LSR_ACTIVE);
  assign ref_pb     = is_refresh && cke && !cmd_addr[3] &&
                      (state_q == LSR_ACTIVE);

  // Previous cke sample
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      cke_prev_q <= 1'b1;
    else
      cke_prev_q <= cke;

  // Mode register writes for bank and segment masks
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bank_mask_q <= `LSR_BANK_MASK_RST;
      seg_mask_q  <= `LSR_SEG_MASK_RST;
    end
    else if (mrw_valid && state_q == LSR_ACTIVE)
    begin
      if (mrw_addr == `LSR_BANK_MASK_ADDR)
        bank_mask_q <= mrw_data;
      if (mrw_addr == `LSR_SEG_MASK_ADDR)
        seg_mask_q <= mrw_data;
    end
  end

  // Self-refresh state machine
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= LSR_ACTIVE;
      cnt_q   <= 16'h0000;
    end
    else
    begin
      case (state_q)
        LSR_ACTIVE:
          if (sr_entry)
          begin
            state_q <= LSR_SR_ENTRY;
            cnt_q   <= 16'h0000;
          end
        // Count stops one short so the last exit edge is already active
        LSR_SR_ENTRY:
          if (cke)
          begin
            state_q <= LSR_SR_EXIT;
            cnt_q   <= 16'(`LSR_XSR_CYC - 2);
          end
          else
            state_q <= LSR_SELF_REFRESH;
        LSR_SELF_REFRESH:
          if (cke)
          begin
            state_q <= LSR_SR_EXIT;
            cnt_q   <= 16'(`LSR_XSR_CYC - 2);
          end
        LSR_SR_EXIT:
          if (sr_entry)
            state_q <= LSR_SR_ENTRY;
          else if (cnt_q == 16'h0000)
            state_q <= LSR_ACTIVE;
          else
            cnt_q <= cnt_q - 16'h0001;
        default:
          state_q <= LSR_ACTIVE;
      endcase
    end
  end

  // Internal refresh timer while in self refresh
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sr_timer_q <= 16'h0000;
      sr_done_q  <= 1'b0;
    end
    else if (state_q == LSR_SR_ENTRY)
    begin
      sr_timer_q <= 16'h0000;
      sr_done_q  <= 1'b1; // first refresh at entry
    end
    else if (state_q == LSR_SELF_REFRESH)
    begin
      sr_done_q <= 1'b0;
      if (sr_timer_q == 16'(`LSR_SR_TIMER_CYC - 1))
      begin
        sr_timer_q <= 16'h0000;
        sr_done_q  <= 1'b1;
      end
      else
        sr_timer_q <= sr_timer_q + 16'h0001;
    end
    else
      sr_done_q <= 1'b0;
  end

  // Internal refresh strobes, masked banks excluded
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bank_refresh_q <= 8'h00;
      seg_refresh_q  <= 8'h00;
    end
    else if (sr_done_q)
    begin
      bank_refresh_q <= ~bank_mask_q;
      seg_refresh_q  <= ~seg_mask_q;
    end
    else
    begin
      bank_refresh_q <= 8'h00;
      seg_refresh_q  <= 8'h00;
    end
  end

  // Round-robin per-bank pointer
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      pb_bank_q <= 3'h0;
    else if ((state_q == LSR_SR_EXIT && cnt_q == 16'h0000) || ref_ab)
      pb_bank_q <= 3'h0;
    else if (ref_pb)
      pb_bank_q <= pb_bank_q + 3'h1;

  // Busy tracking: only the refreshed bank(s) are blocked
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bank_busy_q <= 8'h00;
      rfc_q       <= 16'h0000;
    end
    else if (ref_ab)
    begin
      bank_busy_q <= 8'hFF;
      rfc_q       <= 16'(`LSR_RFCAB_CYC - 1);
    end
    else if (ref_pb)
    begin
      bank_busy_q <= 8'h01 << pb_bank_q;
      rfc_q       <= 16'(`LSR_RFCPB_CYC - 1);
    end
    else if (rfc_q != 16'h0000)
      rfc_q <= rfc_q - 16'h0001;
    else
      bank_busy_q <= 8'h00;
  end

  // Status outputs
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      self_refresh_q <= 1'b0;
      int_clk_en_q   <= 1'b1;
      exit_busy_q    <= 1'b0;
    end
    else
    begin
      self_refresh_q <= (state_q == LSR_SR_ENTRY) ||
                        (state_q == LSR_SELF_REFRESH && !cke);
      int_clk_en_q   <= !(state_q == LSR_SELF_REFRESH && !cke);
      exit_busy_q    <= (state_q == LSR_SR_EXIT) ||
                        (state_q == LSR_SELF_REFRESH && cke);
    end
  end

  chk_entry_goes_sr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == LSR_ACTIVE && sr_entry) |=> ##1 self_refresh_q)
    else $error("self refresh not flagged after entry");

  sequence sr_entered;
    state_q == LSR_ACTIVE && sr_entry;
  endsequence
  chk_internal_refresh: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    sr_entered |-> ##3 (bank_refresh_q == ~bank_mask_q))
    else $error("no internal refresh after entry");

  chk_masked_skip: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (bank_refresh_q & bank_mask_q) == 8'h00)
    else $error("masked bank refreshed");

  chk_exit_delay: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == LSR_SELF_REFRESH && cke) |=> (state_q == LSR_SR_EXIT)
      [*8])
    else $error("exit delay shorter than expected");

  chk_pb_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == LSR_SR_EXIT && cnt_q == 16'h0000 && !sr_entry)
      |=> pb_bank_q == 3'h0)
    else $error("bank pointer not reset on exit");

  chk_pb_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ref_pb |=> $countones(bank_busy_q) == 1)
    else $error("per-bank refresh blocks other banks");

  chk_no_pd_refresh: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (state_q == LSR_ACTIVE) [*2] |=> (bank_refresh_q == 8'h00))
    else $error("refresh outside self refresh");

  chk_clk_gated: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_q == LSR_SELF_REFRESH && !cke) |=> !int_clk_en_q)
    else $error("internal clock not gated");

  chk_mask_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (mrw_valid && state_q == LSR_ACTIVE && mrw_addr == `LSR_BANK_MASK_ADDR)
      |=> bank_mask_q == $past(mrw_data))
    else $error("bank mask not written");

endmodule : lsr_refresh
`default_nettype wire

// ---- pkg/lsr_map.svh ----
// Purpose: Register offsets, reset values and timing counts for refresh logic
// Assumes: 100 MHz device clock (10 ns period)
// Notes:   Definitions only
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH
`define LSR_BANK_MASK_ADDR     8'h10
`define LSR_SEG_MASK_ADDR      8'h11
`define LSR_BANK_MASK_RST      8'h00
`define LSR_SEG_MASK_RST       8'h00
`define LSR_CLK_NS             10
`define LSR_RESIDENCY_NS       150
`define LSR_RESIDENCY_CYC      ((`LSR_RESIDENCY_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_XSR_NS             140
`define LSR_XSR_CYC            ((`LSR_XSR_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_RFCPB_NS           60
`define LSR_RFCPB_CYC          ((`LSR_RFCPB_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_RFCAB_NS           130
`define LSR_RFCAB_CYC          ((`LSR_RFCAB_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_SR_TIMER_CYC       64
`define LSR_NUM_BANKS          8
`endif

// ---- pkg/lsr_pkg.sv ----
// Purpose: Types for the refresh / self-refresh block
// Assumes: Used with lsr_map.svh
// Notes:   States only; numbers live in the map header
`default_nettype none
package lsr_pkg;
  typedef enum logic [2:0] {
    LSR_ACTIVE,
    LSR_SR_ENTRY,
    LSR_SELF_REFRESH,
    LSR_SR_EXIT
  } lsr_state_type;
endpackage : lsr_pkg
`default_nettype wire

// ---- tb/lsr_ctrl_model.sv ----
// Purpose: Command-side controller model for the refresh block
// Assumes: Commands launched 1 ns after rising sys_clk
// Notes:   Don't-care pins are scrambled while in self refresh
`default_nettype none
module lsr_ctrl_model (
  input  wire logic       sys_clk,
  output var  logic       cke,
  output var  logic       cs_n,
  output var  logic [9:0] cmd_addr,
  output var  logic       mrw_valid,
  output var  logic [7:0] mrw_addr,
  output var  logic [7:0] mrw_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic in_sr;
  // Idle pins at time zero
  initial
  begin
    {cke, cs_n, cmd_addr, mrw_valid, mrw_addr, mrw_data} = {2'h3, 27'h0};
    in_sr = 1'b0;
  end
  // Only cs_n and cmd_addr toggle while resident
  always @(posedge sys_clk)
    if (in_sr)
    begin
      #1;
      cs_n     = ~cs_n;
      cmd_addr = ~cmd_addr;
    end
  task automatic nop();
    @(posedge sys_clk);
    #1;
    cs_n      = 1'b1;
    mrw_valid = 1'b0;
  endtask : nop
  // Refresh, then idle past the refresh cycle so banks are idle again
  task automatic refresh(input logic all_bank);
    @(posedge sys_clk);
    #1;
    cs_n     = 1'b0;
    cmd_addr = {6'h00, all_bank, 3'h4};
    repeat (15) nop();
  endtask : refresh
  task automatic mode_reg_write_cmd(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    {mrw_valid, mrw_addr, mrw_data} = {1'b1, addr, data};
    nop();
  endtask : mode_reg_write_cmd
  task automatic sr_enter();
    @(posedge sys_clk);
    #1;
    {cke, cs_n, cmd_addr} = {2'h0, 10'h004};
    nop();
    in_sr = 1'b1;
  endtask : sr_enter
  // Two NOPs of stable clock first, then cke high; the caller waits out the exit delay
  task automatic sr_exit();
    in_sr = 1'b0;
    repeat (2) nop();
    cke = 1'b1;
  endtask : sr_exit
endmodule : lsr_ctrl_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the refresh / self-refresh block
// Assumes: 100 MHz sys_clk, reset held 10 cycles
// Notes:   Stimulus comes through the controller model tasks
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk, arst_n, cke, cs_n, mrw_valid;
  logic [9:0] cmd_addr;
  logic [7:0] mrw_addr, mrw_data, bank_refresh_q, seg_refresh_q, bank_busy_q;
  logic       self_refresh_q, int_clk_en_q, exit_busy_q;
  logic [2:0] pb_bank_q;
  int         error_cnt, checks_done, cyc;
  lsr_ctrl_model i_ctrl (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n),
    .cmd_addr(cmd_addr), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
    .mrw_data(mrw_data));
  lsr_refresh i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cke(cke),
    .cs_n(cs_n), .cmd_addr(cmd_addr), .mrw_valid(mrw_valid),
    .mrw_addr(mrw_addr), .mrw_data(mrw_data),
    .self_refresh_q(self_refresh_q), .int_clk_en_q(int_clk_en_q),
    .exit_busy_q(exit_busy_q), .bank_refresh_q(bank_refresh_q),
    .seg_refresh_q(seg_refresh_q), .pb_bank_q(pb_bank_q),
    .bank_busy_q(bank_busy_q));
  // Clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic t_reset();
    chk({7'h00, self_refresh_q}, 8'h00);
    chk({7'h00, int_clk_en_q}, 8'h01);
    chk({7'h00, exit_busy_q}, 8'h00);
    chk(bank_refresh_q, 8'h00);
    chk({5'h00, pb_bank_q}, 8'h00);
    chk(bank_busy_q, 8'h00);
  endtask : t_reset
  // Per-bank advances round robin, all-bank returns pointer to zero
  task automatic t_pointer();
    repeat (3) i_ctrl.refresh(1'b0);
    chk({5'h00, pb_bank_q}, 8'h03);
    i_ctrl.refresh(1'b1);
    chk({5'h00, pb_bank_q}, 8'h00);
    repeat (2) i_ctrl.refresh(1'b0);
    chk({5'h00, pb_bank_q}, 8'h02);
  endtask : t_pointer
  // Masked banks 1 and 7, masked segments 2 and 7
  task automatic t_self_refresh();
    i_ctrl.mode_reg_write_cmd(8'h10, 8'h82);
    i_ctrl.mode_reg_write_cmd(8'h11, 8'h84);
    i_ctrl.sr_enter();
    @(posedge sys_clk);
    #1;
    chk({7'h00, self_refresh_q}, 8'h01);
    // Refresh pulse and clock gating follow one edge later
    @(posedge sys_clk);
    #1;
    chk({7'h00, int_clk_en_q}, 8'h00);
    chk(bank_refresh_q, 8'h7D);
    chk(seg_refresh_q, 8'h7B);
    @(posedge sys_clk);
    #1;
    chk(bank_refresh_q, 8'h00);
    repeat (63) @(posedge sys_clk);
    #1;
    chk(bank_refresh_q, 8'h7D);
    chk({7'h00, self_refresh_q}, 8'h01);
  endtask : t_self_refresh
  task automatic t_exit();
    int w;
    int n;
    w = 0;
    n = 0;
    i_ctrl.sr_exit();
    while (exit_busy_q !== 1'b1 && w < 4)
    begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    while (exit_busy_q === 1'b1 && n < 30)
    begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    chk(n[7:0], 8'h0E);
    chk({5'h00, pb_bank_q}, 8'h00);
    chk({7'h00, self_refresh_q}, 8'h00);
    chk({7'h00, int_clk_en_q}, 8'h01);
    // All banks busy while the all-bank refresh runs
    fork
      i_ctrl.refresh(1'b1);
      begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk(bank_busy_q, 8'hFF);
      end
    join
    chk({5'h00, pb_bank_q}, 8'h00);
    chk(bank_busy_q, 8'h00);
  endtask : t_exit
  // Main sequence
  initial
  begin
    arst_n      = 1'b0;
    error_cnt   = 0;
    checks_done = 0;
    cyc         = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    t_reset();
    arst_n = 1'b1;
    t_pointer();
    t_self_refresh();
    t_exit();
    summarize();
  end
endmodule : testbench
`default_nettype wire
